// ---- hw/pll_ctrl_map.vh ----
// Purpose: Register map, field positions and lookup constants of the lock
//          detector and pump control block.
// Assumes: 32-bit register words on byte addresses.
// Notes:   Definitions only.
`ifndef PLL_CTRL_MAP_VH
`define PLL_CTRL_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_PUMP 8'h04
`define REG_DELAY 8'h08
`define REG_OSC_MANUAL 8'h0c
`define REG_OSC_READBACK 8'h10
`define REG_STATUS 8'h14
`define REG_INT_STATUS 8'h18
`define REG_INT_MASK 8'h1c

// ****************************************
// Field positions
// ****************************************
`define CTRL_LOL_EN 0
`define CTRL_WIN_EN 1
`define CTRL_WIN_WIDTH 2
`define CTRL_COUNT_LSB 4
`define CTRL_MUX_LSB 10
`define CTRL_INVERT 12
`define PUMP_CUR_LSB 0
`define PUMP_TEST 4
`define PUMP_SRC 5
`define PUMP_SNK 6
`define PUMP_BLEED_EN 7
`define PUMP_BLEED_POLARITY 8
`define PUMP_BLEED_LSB 16
`define DELAY_FB_LSB 8
`define OSC_BAND_LSB 8
`define OSC_BIAS_LSB 16
`define OSC_MANUAL_EN 31
`define INT_ACQUIRED 0
`define INT_LOST 1

// ****************************************
// Reset values and encodings
// ****************************************
`define CTRL_RESET 32'h0000_0000
`define PUMP_RESET 32'h0000_000f
`define MUX_LOW 2'h0
`define MUX_LOCK 2'h1
`define MUX_IRQ 2'h2
`define MUX_HIGH 2'h3
`define BLEED_STEP_NA 20'd536

// ****************************************
// Required phase-detector cycles per lock count code
// ****************************************
`define LD_CNT_00 21'd23
`define LD_CNT_01 21'd32
`define LD_CNT_02 21'd47
`define LD_CNT_03 21'd66
`define LD_CNT_04 21'd95
`define LD_CNT_05 21'd134
`define LD_CNT_06 21'd191
`define LD_CNT_07 21'd270
`define LD_CNT_08 21'd383
`define LD_CNT_09 21'd542
`define LD_CNT_10 21'd767
`define LD_CNT_11 21'd1085
`define LD_CNT_12 21'd1535
`define LD_CNT_13 21'd2171
`define LD_CNT_14 21'd3071
`define LD_CNT_15 21'd4343
`define LD_CNT_16 21'd6143
`define LD_CNT_17 21'd8687
`define LD_CNT_18 21'd12287
`define LD_CNT_19 21'd17376
`define LD_CNT_20 21'd24575
`define LD_CNT_21 21'd34754
`define LD_CNT_22 21'd49151
`define LD_CNT_23 21'd69510
`define LD_CNT_24 21'd98303
`define LD_CNT_25 21'd139021
`define LD_CNT_26 21'd196607
`define LD_CNT_27 21'd278044
`define LD_CNT_28 21'd393215
`define LD_CNT_29 21'd556090
`define LD_CNT_30 21'd786431
`define LD_CNT_31 21'd1112181

// ****************************************
// Pump current per code, in units of 10 uA
// ****************************************
`define CP_UA10_00 11'd79
`define CP_UA10_01 11'd99
`define CP_UA10_02 11'd119
`define CP_UA10_03 11'd138
`define CP_UA10_04 11'd159
`define CP_UA10_05 11'd198
`define CP_UA10_06 11'd239
`define CP_UA10_07 11'd279
`define CP_UA10_08 11'd318
`define CP_UA10_09 11'd397
`define CP_UA10_10 11'd477
`define CP_UA10_11 11'd557
`define CP_UA10_12 11'd633
`define CP_UA10_13 11'd791
`define CP_UA10_14 11'd951
`define CP_UA10_15 11'd1110

`endif

// ---- hw/lock_count_table.v ----
// Purpose: Decode of the lock count code into required cycles.
// Assumes: Purely combinational.
// Notes:   Table is fixed.
`timescale 1ns/1ns
`include "pll_ctrl_map.vh"
module lock_count_table (
  // Code in.
  input wire [4:0] code,
  // Required cycles out.
  output reg [20:0] cycles
);
  always @*
  begin
    case (code)
      5'h00: cycles = `LD_CNT_00;
      5'h01: cycles = `LD_CNT_01;
      5'h02: cycles = `LD_CNT_02;
      5'h03: cycles = `LD_CNT_03;
      5'h04: cycles = `LD_CNT_04;
      5'h05: cycles = `LD_CNT_05;
      5'h06: cycles = `LD_CNT_06;
      5'h07: cycles = `LD_CNT_07;
      5'h08: cycles = `LD_CNT_08;
      5'h09: cycles = `LD_CNT_09;
      5'h0a: cycles = `LD_CNT_10;
      5'h0b: cycles = `LD_CNT_11;
      5'h0c: cycles = `LD_CNT_12;
      5'h0d: cycles = `LD_CNT_13;
      5'h0e: cycles = `LD_CNT_14;
      5'h0f: cycles = `LD_CNT_15;
      5'h10: cycles = `LD_CNT_16;
      5'h11: cycles = `LD_CNT_17;
      5'h12: cycles = `LD_CNT_18;
      5'h13: cycles = `LD_CNT_19;
      5'h14: cycles = `LD_CNT_20;
      5'h15: cycles = `LD_CNT_21;
      5'h16: cycles = `LD_CNT_22;
      5'h17: cycles = `LD_CNT_23;
      5'h18: cycles = `LD_CNT_24;
      5'h19: cycles = `LD_CNT_25;
      5'h1a: cycles = `LD_CNT_26;
      5'h1b: cycles = `LD_CNT_27;
      5'h1c: cycles = `LD_CNT_28;
      5'h1d: cycles = `LD_CNT_29;
      5'h1e: cycles = `LD_CNT_30;
      default: cycles = `LD_CNT_31;
    endcase
  end
endmodule

// ---- hw/pump_current_table.v ----
// Purpose: Decode of the pump current code into a magnitude in 10 uA units.
// Assumes: Purely combinational.
// Notes:   Magnitudes rise with the code.
`timescale 1ns/1ns
`include "pll_ctrl_map.vh"
module pump_current_table (
  // Code in.
  input wire [3:0] code,
  // Magnitude out.
  output reg [10:0] ua10
);
  always @*
  begin
    case (code)
      4'h0: ua10 = `CP_UA10_00;
      4'h1: ua10 = `CP_UA10_01;
      4'h2: ua10 = `CP_UA10_02;
      4'h3: ua10 = `CP_UA10_03;
      4'h4: ua10 = `CP_UA10_04;
      4'h5: ua10 = `CP_UA10_05;
      4'h6: ua10 = `CP_UA10_06;
      4'h7: ua10 = `CP_UA10_07;
      4'h8: ua10 = `CP_UA10_08;
      4'h9: ua10 = `CP_UA10_09;
      4'ha: ua10 = `CP_UA10_10;
      4'hb: ua10 = `CP_UA10_11;
      4'hc: ua10 = `CP_UA10_12;
      4'hd: ua10 = `CP_UA10_13;
      4'he: ua10 = `CP_UA10_14;
      default: ua10 = `CP_UA10_15;
    endcase
  end
endmodule

// ---- hw/pll_lock_detect_and_cp_control.v ----
// Purpose: Lock detector, pump test decode, bleed and delay settings and
//          oscillator selection behind a simple register port.
// Assumes: Each sys_clk cycle stands for one phase-detector cycle; the
//          window comparators and pump pulses arrive asynchronously.
// Notes:   Lock drop is seen three edges after the window is left.
`timescale 1ns/1ns
`include "pll_ctrl_map.vh"
// Function
// - Lock detector runs only with loss-of-lock and window enables both set.
// - Lock drives its pin, the locked status bit, and optionally the mux pin.
// - Lock asserts only after phase error stays inside window for required cycles.
// - Count code 0 to 31 decodes through fixed table, 23 to 1112181.
// - Inside window before the count is reached, output low, keep counting.
// - Count reached or passed drives lock high while inside window.
// - Width bit picks 150 ps window at 0 or 250 ps at 1.
// - Test mode floats, sources or sinks pump by the force bits.
// - Sixteen current codes map to rising magnitudes 0.79 to 11.1 mA.
// - Bleed enable applies bleed current, sourcing at polarity 1, sinking at 0.
// - Ten-bit bleed magnitude scales current in 536 nA steps.
// - Seven-bit reference delay field, about 1 ps per code.
// - Four cores of 256 bands; calibrated core, band, bias are readable.
// - Manually written core, band, bias are used instead of calibration.
module pll_lock_detect_and_cp_control #(
  parameter LOCK_SHIFT = 0
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Phase detector window comparators and pump pulses.
  input wire in_window_narrow,
  input wire in_window_wide,
  input wire pd_up,
  input wire pd_down,
  // Calibration results.
  input wire [1:0] cal_core,
  input wire [7:0] cal_band,
  input wire [3:0] cal_bias,
  // Lock outputs.
  output reg lock_indicator_pin,
  output reg multiplexed_output_pin,
  output reg irq,
  // Pump drive.
  output reg pump_source,
  output reg pump_sink,
  output reg pump_hiz,
  output reg [10:0] pump_current_ua10,
  // Bleed and delays.
  output reg bleed_source,
  output reg bleed_sink,
  output reg [19:0] bleed_current_na,
  output reg [6:0] reference_path_delay,
  output reg [6:0] feedback_path_delay,
  output reg output_phase_invert,
  // Oscillator selection.
  output reg [1:0] osc_core_sel,
  output reg [7:0] osc_band_sel,
  output reg [3:0] osc_bias_sel
);

  // ****************************************
  // Declarations
  // ****************************************
  reg [31:0] ctrl;
  reg [31:0] pump;
  reg [31:0] delay;
  reg [31:0] osc_manual;
  reg [1:0] int_status;
  reg [1:0] int_mask;
  reg [1:0] next_int_status;
  reg [31:0] next_rdata;
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg [20:0] count;
  reg locked;
  reg next_locked;
  reg [20:0] next_count;
  reg next_mux;
  wire [20:0] table_cycles;
  wire [20:0] shifted;
  wire [20:0] required;
  wire [10:0] cur_ua10;
  wire [4:0] count_code;
  wire [1:0] mux_sel;
  wire run;
  wire in_win;
  wire acquired;
  wire lost;
  wire manual;

  assign count_code = ctrl[`CTRL_COUNT_LSB+4:`CTRL_COUNT_LSB];
  assign mux_sel = ctrl[`CTRL_MUX_LSB+1:`CTRL_MUX_LSB];
  assign manual = osc_manual[`OSC_MANUAL_EN];

  // ****************************************
  // Lookups
  // ****************************************
  lock_count_table u_count (
    .code(count_code),
    .cycles(table_cycles)
  );

  pump_current_table u_current (
    .code(pump[`PUMP_CUR_LSB+3:`PUMP_CUR_LSB]),
    .ua10(cur_ua10)
  );

  // A shortened count is kept at one cycle at least.
  assign shifted = table_cycles >> LOCK_SHIFT;
  assign required = (shifted == 21'h0) ? 21'h1 : shifted;

  function [1:0] w1c_mask;
    input [31:0] wdata;
    input [1:0] cur;
    begin
      w1c_mask = cur & ~wdata[1:0];
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // The first stage feeds nothing but the second.
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= {pd_down, pd_up, in_window_wide, in_window_narrow};
      sync_b <= sync_a;
    end
  end

  assign run = ctrl[`CTRL_LOL_EN] & ctrl[`CTRL_WIN_EN];
  assign in_win = ctrl[`CTRL_WIN_WIDTH] ? sync_b[1] : sync_b[0];

  // ****************************************
  // Lock detector
  // ****************************************
  always @*
  begin
    next_count = count;
    next_locked = locked;
    if (!run)
    begin
      next_count = 21'h0;
      next_locked = 1'b0;
    end
    else if (!in_win)
    begin
      next_count = 21'h0;
      next_locked = 1'b0;
    end
    else if (count + 21'h1 >= required)
    begin
      next_count = count;
      next_locked = 1'b1;
    end
    else
    begin
      next_count = count + 21'h1;
      next_locked = 1'b0;
    end
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      count <= 21'h0;
      locked <= 1'b0;
    end
    else
    begin
      count <= next_count;
      locked <= next_locked;
    end
  end

  assign acquired = next_locked & ~locked;
  assign lost = locked & ~next_locked;

  always @*
  begin
    case (mux_sel)
      `MUX_LOCK: next_mux = next_locked;
      `MUX_IRQ: next_mux = |(next_int_status & int_mask);
      `MUX_HIGH: next_mux = 1'b1;
      default: next_mux = 1'b0;
    endcase
  end

  // ****************************************
  // Register writes and interrupt status
  // ****************************************
  // A new event wins over a clearing write in the same cycle.
  always @*
  begin
    next_int_status = int_status;
    if (reg_wr && reg_addr == `REG_INT_STATUS)
      next_int_status = w1c_mask(reg_wdata, int_status);
    if (acquired)
      next_int_status[`INT_ACQUIRED] = 1'b1;
    if (lost)
      next_int_status[`INT_LOST] = 1'b1;
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl <= `CTRL_RESET;
      pump <= `PUMP_RESET;
      delay <= 32'h0;
      osc_manual <= 32'h0;
      int_status <= 2'h0;
      int_mask <= 2'h0;
    end
    else
    begin
      int_status <= next_int_status;
      if (reg_wr)
      begin
        case (reg_addr)
          `REG_CTRL: ctrl <= reg_wdata & 32'h0000_1df7;
          `REG_PUMP: pump <= reg_wdata & 32'h03ff_01ff;
          `REG_DELAY: delay <= reg_wdata & 32'h0000_7f7f;
          `REG_OSC_MANUAL: osc_manual <= reg_wdata & 32'h800f_ff03;
          `REG_INT_MASK: int_mask <= reg_wdata[1:0];
          default: int_mask <= int_mask;
        endcase
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always @*
  begin
    next_rdata = 32'h0;
    case (reg_addr)
      `REG_CTRL: next_rdata = ctrl;
      `REG_PUMP: next_rdata = pump;
      `REG_DELAY: next_rdata = delay;
      `REG_OSC_MANUAL: next_rdata = osc_manual;
      `REG_OSC_READBACK: next_rdata = {12'h0, cal_bias, cal_band, 6'h0, cal_core};
      `REG_STATUS: next_rdata = {31'h0, locked};
      `REG_INT_STATUS: next_rdata = {30'h0, int_status};
      `REG_INT_MASK: next_rdata = {30'h0, int_mask};
      default: next_rdata = 32'h0;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h0;
  end

  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lock_indicator_pin <= 1'b0;
      multiplexed_output_pin <= 1'b0;
      irq <= 1'b0;
      pump_source <= 1'b0;
      pump_sink <= 1'b0;
      pump_hiz <= 1'b1;
      pump_current_ua10 <= 11'h0;
      bleed_source <= 1'b0;
      bleed_sink <= 1'b0;
      bleed_current_na <= 20'h0;
      reference_path_delay <= 7'h0;
      feedback_path_delay <= 7'h0;
      output_phase_invert <= 1'b0;
      osc_core_sel <= 2'h0;
      osc_band_sel <= 8'h0;
      osc_bias_sel <= 4'h0;
    end
    else
    begin
      lock_indicator_pin <= next_locked;
      multiplexed_output_pin <= next_mux;
      irq <= |(next_int_status & int_mask);
      pump_current_ua10 <= cur_ua10;
      if (pump[`PUMP_TEST])
      begin
        // Source and sink together never drive both; source is preferred.
        pump_source <= pump[`PUMP_SRC];
        pump_sink <= pump[`PUMP_SNK] & ~pump[`PUMP_SRC];
        pump_hiz <= ~pump[`PUMP_SRC] & ~pump[`PUMP_SNK];
      end
      else
      begin
        pump_source <= sync_b[2];
        pump_sink <= sync_b[3];
        pump_hiz <= ~sync_b[2] & ~sync_b[3];
      end
      bleed_source <= pump[`PUMP_BLEED_EN] & pump[`PUMP_BLEED_POLARITY];
      bleed_sink <= pump[`PUMP_BLEED_EN] & ~pump[`PUMP_BLEED_POLARITY];
      bleed_current_na <= pump[`PUMP_BLEED_EN] ?
        (`BLEED_STEP_NA * {10'h0, pump[`PUMP_BLEED_LSB+9:`PUMP_BLEED_LSB]}) : 20'h0;
      reference_path_delay <= delay[6:0];
      feedback_path_delay <= delay[`DELAY_FB_LSB+6:`DELAY_FB_LSB];
      output_phase_invert <= ctrl[`CTRL_INVERT];
      if (manual)
      begin
        osc_core_sel <= osc_manual[1:0];
        osc_band_sel <= osc_manual[`OSC_BAND_LSB+7:`OSC_BAND_LSB];
        osc_bias_sel <= osc_manual[`OSC_BIAS_LSB+3:`OSC_BIAS_LSB];
      end
      else
      begin
        osc_core_sel <= cal_core;
        osc_band_sel <= cal_band;
        osc_bias_sel <= cal_bias;
      end
    end
  end

endmodule

// ---- verif/lock_ctrl_checker_props.sv ----
// Purpose: Port-level checks of the lock detector and pump control block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: The control word is shadowed from register writes seen at the ports.
`timescale 1ns/1ns
`include "pll_ctrl_map.vh"
module lock_ctrl_checker #(
  parameter LOCK_SHIFT = 0
) (
  // Clock, reset and register writes.
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  // Window comparators.
  input wire in_window_narrow,
  input wire in_window_wide,
  // Observed outputs.
  input wire lock_indicator_pin,
  input wire multiplexed_output_pin,
  input wire irq,
  input wire pump_source,
  input wire pump_sink,
  input wire pump_hiz,
  input wire [10:0] pump_current_ua10,
  input wire bleed_source,
  input wire bleed_sink,
  input wire [19:0] bleed_current_na
);
  reg [31:0] ctrl_sh;
  wire run = ctrl_sh[0] & ctrl_sh[1];
  wire [1:0] mux = ctrl_sh[11:10];
  wire win_any = in_window_narrow | in_window_wide;
  wire win_both = in_window_narrow & in_window_wide;
  wire pump_wr = reg_wr && reg_addr == `REG_PUMP;
  wire [9:0] mag = reg_wdata[25:16];

  always @(posedge sys_clk)
    if (sys_rst)
      ctrl_sh <= 32'h0;
    else if (reg_wr && reg_addr == `REG_CTRL)
      ctrl_sh <= reg_wdata;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Lock detector
  // ****************************************
  property p_run_off;
    !run && !$past(run) |-> !lock_indicator_pin;
  endproperty
  a_run_off: assert property (p_run_off) else $error("lock high while detector off");
  property p_mux_lock;
    mux == `MUX_LOCK && $past(mux) == `MUX_LOCK |->
      multiplexed_output_pin == lock_indicator_pin ||
      multiplexed_output_pin == $past(lock_indicator_pin);
  endproperty
  a_mux_lock: assert property (p_mux_lock) else $error("mux pin does not follow lock");
  property p_mux_high;
    mux == `MUX_HIGH && $past(mux) == `MUX_HIGH |-> multiplexed_output_pin;
  endproperty
  a_mux_high: assert property (p_mux_high) else $error("mux pin not high");
  property p_rise;
    $rose(lock_indicator_pin) |-> run && $past(win_any, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("lock rose outside window");
  property p_hold;
    lock_indicator_pin && run && !reg_wr && win_both && $past(win_both) &&
      $past(win_both, 2) |=> lock_indicator_pin;
  endproperty
  a_hold: assert property (p_hold) else $error("lock fell inside window");
  property p_drop;
    !win_any [*4] |=> !lock_indicator_pin;
  endproperty
  a_drop: assert property (p_drop) else $error("lock held outside window");

  // ****************************************
  // Pump and bleed
  // ****************************************
  property p_float;
    pump_wr && reg_wdata[6:4] == 3'b001 ##1 !reg_wr [*2] |->
      pump_hiz && !pump_source && !pump_sink;
  endproperty
  a_float: assert property (p_float) else $error("pump not floated");
  property p_src;
    pump_wr && reg_wdata[6:4] == 3'b011 ##1 !reg_wr [*2] |->
      pump_source && !pump_sink && !pump_hiz;
  endproperty
  a_src: assert property (p_src) else $error("pump not sourcing");
  property p_cur0;
    pump_wr && reg_wdata[4:0] == 5'h00 ##1 !reg_wr [*2] |-> pump_current_ua10 == `CP_UA10_00;
  endproperty
  a_cur0: assert property (p_cur0) else $error("lowest pump current wrong");
  property p_bleed;
    pump_wr && reg_wdata[8:7] == 2'b11 ##1 !reg_wr [*2] |->
      bleed_source && !bleed_sink && bleed_current_na == `BLEED_STEP_NA * $past(mag, 2);
  endproperty
  a_bleed: assert property (p_bleed) else $error("bleed source current wrong");

  c_lock: cover property ($rose(lock_indicator_pin));
  c_drop: cover property ($fell(lock_indicator_pin));
  c_irq: cover property ($rose(irq));
endmodule

bind pll_lock_detect_and_cp_control lock_ctrl_checker #(.LOCK_SHIFT(LOCK_SHIFT)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .in_window_narrow(in_window_narrow), .in_window_wide(in_window_wide),
  .lock_indicator_pin(lock_indicator_pin), .multiplexed_output_pin(multiplexed_output_pin),
  .irq(irq), .pump_source(pump_source), .pump_sink(pump_sink), .pump_hiz(pump_hiz),
  .pump_current_ua10(pump_current_ua10), .bleed_source(bleed_source),
  .bleed_sink(bleed_sink), .bleed_current_na(bleed_current_na));

// ---- verif/pll_lock_detect_and_cp_control_test.sv ----
// Purpose: Directed register-level test of the lock and pump control block.
// Assumes: 8 ns clock, counts shortened by LOCK_SHIFT.
// Notes: Lock timing is bounded loosely because of the input synchronisers.
`timescale 1ns/1ns
`include "pll_ctrl_map.vh"
module pll_lock_detect_and_cp_control_test;
  localparam SH = 8;
  reg sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg in_window_narrow = 1'b1, in_window_wide = 1'b1, pd_up = 1'b0, pd_down = 1'b0;
  reg [1:0] cal_core = 2'h2;
  reg [7:0] cal_band = 8'ha5;
  reg [3:0] cal_bias = 4'h9;
  wire [31:0] reg_rdata;
  wire lock_indicator_pin, multiplexed_output_pin, irq, pump_source, pump_sink, pump_hiz;
  wire bleed_source, bleed_sink, output_phase_invert;
  wire [10:0] pump_current_ua10;
  wire [19:0] bleed_current_na;
  wire [6:0] reference_path_delay, feedback_path_delay;
  wire [1:0] osc_core_sel;
  wire [7:0] osc_band_sel;
  wire [3:0] osc_bias_sel;
  wire [175:0] cur_tbl = {`CP_UA10_15, `CP_UA10_14, `CP_UA10_13, `CP_UA10_12, `CP_UA10_11,
    `CP_UA10_10, `CP_UA10_09, `CP_UA10_08, `CP_UA10_07, `CP_UA10_06, `CP_UA10_05,
    `CP_UA10_04, `CP_UA10_03, `CP_UA10_02, `CP_UA10_01, `CP_UA10_00};
  integer bad_count = 0, num_checks = 0, n, i;
  integer r31 = `LD_CNT_31 >> SH;
  integer r18 = `LD_CNT_18 >> SH;

  pll_lock_detect_and_cp_control #(.LOCK_SHIFT(SH)) DUT (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_window_narrow(in_window_narrow),
    .in_window_wide(in_window_wide), .pd_up(pd_up), .pd_down(pd_down), .cal_core(cal_core),
    .cal_band(cal_band), .cal_bias(cal_bias), .lock_indicator_pin(lock_indicator_pin),
    .multiplexed_output_pin(multiplexed_output_pin), .irq(irq), .pump_source(pump_source),
    .pump_sink(pump_sink), .pump_hiz(pump_hiz), .pump_current_ua10(pump_current_ua10),
    .bleed_source(bleed_source), .bleed_sink(bleed_sink),
    .bleed_current_na(bleed_current_na), .reference_path_delay(reference_path_delay),
    .feedback_path_delay(feedback_path_delay), .output_phase_invert(output_phase_invert),
    .osc_core_sel(osc_core_sel), .osc_band_sel(osc_band_sel), .osc_bias_sel(osc_bias_sel));

  always #4 sys_clk = ~sys_clk;

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task tick(input integer k);
    begin
      repeat (k) @(posedge sys_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
    end
  endtask
  // A bounded wait, so a detector that never locks still ends the test.
  task lock_in(input integer r);
    begin
      n = 0;
      while (lock_indicator_pin !== 1'b1 && n < 6000)
      begin
        tick(1);
        n = n + 1;
      end
      chk(n >= r - 2 && n <= r + 4, 32'h1);
    end
  endtask
  task end_sim;
    begin
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial
  begin
    #(8 * 40000);
    bad_count = bad_count + 1;
    end_sim;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
    chk(pump_current_ua10, `CP_UA10_15);
    rchk(`REG_PUMP, `PUMP_RESET);
    rchk(`REG_OSC_READBACK, 32'h0009_a502);
    chk({osc_core_sel, osc_band_sel, osc_bias_sel}, {2'h2, 8'ha5, 4'h9});
    wr(`REG_OSC_MANUAL, 32'h8003_5c01);
    tick(2);
    chk({osc_core_sel, osc_band_sel, osc_bias_sel}, {2'h1, 8'h5c, 4'h3});
    rchk(`REG_OSC_READBACK, 32'h0009_a502);
    rchk(8'hfc, 32'h0);
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(`REG_PUMP, i);
      tick(2);
      chk(pump_current_ua10, cur_tbl[i * 11 +: 11]);
    end
    @(posedge sys_clk) pd_up <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`REG_PUMP, 32'h10 + i * 32'h20);
      tick(2);
      chk({pump_source, pump_sink, pump_hiz}, 12'b100_010_100_001 >> (i * 3) & 3'h7);
    end
    wr(`REG_PUMP, 32'h0);
    tick(4);
    chk({pump_source, pump_sink, pump_hiz}, 3'b100);
    @(posedge sys_clk) {pd_up, pd_down} <= 2'b01;
    tick(4);
    chk({pump_source, pump_sink, pump_hiz}, 3'b010);
    wr(`REG_PUMP, 32'h03ff_0180);
    tick(2);
    chk({bleed_source, bleed_sink, bleed_current_na}, {2'b10, 20'd1023 * `BLEED_STEP_NA});
    wr(`REG_PUMP, 32'h0200_0080);
    tick(2);
    chk({bleed_source, bleed_sink, bleed_current_na}, {2'b01, 20'd512 * `BLEED_STEP_NA});
    wr(`REG_PUMP, 32'h03ff_0100);
    tick(2);
    chk({bleed_source, bleed_sink, bleed_current_na}, 22'h0);
    wr(`REG_DELAY, 32'h557f);
    tick(2);
    chk({feedback_path_delay, reference_path_delay}, {7'h55, 7'h7f});
    wr(`REG_CTRL, 32'h0121);
    tick(100);
    chk(lock_indicator_pin, 1'b0);
    wr(`REG_INT_MASK, 32'h1);
    wr(`REG_CTRL, 32'h15f3);
    lock_in(r31);
    tick(2);
    chk({multiplexed_output_pin, output_phase_invert, irq}, 3'b111);
    rchk(`REG_STATUS, 32'h1);
    rchk(`REG_INT_STATUS, 32'h1);
    wr(`REG_INT_STATUS, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    wr(`REG_CTRL, 32'h1523);
    tick(2);
    chk(lock_indicator_pin, 1'b1);
    @(posedge sys_clk) {in_window_narrow, in_window_wide} <= 2'b00;
    tick(4);
    chk({lock_indicator_pin, multiplexed_output_pin}, 2'b00);
    rchk(`REG_INT_STATUS, 32'h2);
    @(posedge sys_clk) {in_window_narrow, in_window_wide} <= 2'b11;
    lock_in(r18);
    @(posedge sys_clk) in_window_narrow <= 1'b0;
    tick(4);
    chk(lock_indicator_pin, 1'b0);
    wr(`REG_CTRL, 32'h0d27);
    lock_in(r18);
    chk(multiplexed_output_pin, 1'b1);
    wr(`REG_CTRL, 32'h0127);
    tick(2);
    chk({lock_indicator_pin, multiplexed_output_pin}, 2'b10);
    wr(`REG_CTRL, 32'h0123);
    tick(5);
    chk(lock_indicator_pin, 1'b0);
    // Both events are pending now; route the interrupt level to the mux pin.
    wr(`REG_CTRL, 32'h0923);
    wr(`REG_INT_MASK, 32'h2);
    tick(2);
    chk({irq, multiplexed_output_pin}, 2'b11);
    wr(`REG_INT_STATUS, 32'h3);
    tick(2);
    chk({irq, multiplexed_output_pin}, 2'b00);
    end_sim;
  end
endmodule
